// *** lcdi_pkg.sv ***
/*
 * Shared constants for the two-wire display command link: slave address,
 * control byte fields, instruction encodings, power-up settings and the
 * register map and timing of the bus master end.
 * Assumes a 100 MHz system clock at both ends.
 */
package lcdi_pkg;
	// Display side.
	localparam int          RAM_DEPTH     = 80;
	localparam logic [6:0]  RAM_LAST      = 7'h4f;
	localparam logic [7:0]  BLANK_CHAR    = 8'h20;
	localparam logic [4:0]  SLAVE_ADDR_HI = 5'h0f;
	localparam int          CTRL_CONT_BIT = 7;
	localparam int          CTRL_SEL_BIT  = 6;
	localparam logic [7:0]  INS_CLEAR     = 8'b0000_0001;
	localparam logic [7:0]  INS_HOME      = 8'b0000_001?;
	localparam logic [7:0]  INS_ENTRY     = 8'b0000_01??;
	localparam logic [7:0]  INS_ONOFF     = 8'b0000_1???;
	localparam logic [7:0]  INS_SHIFT     = 8'b0001_????;
	localparam logic [7:0]  INS_FUNC      = 8'b001?_????;
	localparam logic [7:0]  INS_CGRAM     = 8'b01??_????;
	localparam logic [7:0]  INS_DISPLAY_TEXT_RAM     = 8'b1???_????;
	localparam logic        BUS_WIDTH_RST = 1'b1;
	localparam logic        LINES_RST     = 1'b0;
	localparam logic        FONT_RST      = 1'b0;
	localparam logic        DISP_ON_RST   = 1'b0;
	localparam logic        CURSOR_RST    = 1'b0;
	localparam logic        BLINK_RST     = 1'b0;
	localparam logic        INC_RST       = 1'b1;
	localparam logic        SHIFT_RST     = 1'b0;
	// Master side registers.
	localparam logic [3:0]  REG_CMD       = 4'h0;
	localparam logic [3:0]  REG_STATUS    = 4'h4;
	localparam int          CMD_START_BIT = 8;
	localparam int          CMD_STOP_BIT  = 9;
	localparam int          CMD_READ_BIT  = 10;
	localparam int          CMD_NACK_BIT  = 11;
	localparam int          STAT_BUSY_BIT = 0;
	localparam int          STAT_NACK_BIT = 1;
	localparam int          STAT_RX_LSB   = 8;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;
	// Master side timing.
	localparam int          SYS_CLK_NS    = 10;
	localparam int          SCL_PERIOD_NS = 4000;
	localparam int          SCL_QUARTER   = SCL_PERIOD_NS / (4 * SYS_CLK_NS);
	localparam logic [7:0]  SCL_QTR_LAST  = 8'(SCL_QUARTER - 1);
endpackage

// *** lcdi_if.sv ***
/*
 * Two-wire link between the bus master and the display receiver.
 * Both lines are open drain with pull-ups; the wire levels are resolved
 * here from each party's output and output enable.
 */
`timescale 1ns/100ps
interface lcdi_if;
	logic scl_m_o;
	logic scl_m_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic scl;
	logic sda;

	assign scl = !(scl_m_oe && !scl_m_o);
	assign sda = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));

	modport device (
		input  scl,
		input  sda,
		output sda_d_o,
		output sda_d_oe
	);
	modport host (
		input  scl,
		input  sda,
		output scl_m_o,
		output scl_m_oe,
		output sda_m_o,
		output sda_m_oe
	);
endinterface

// *** lcdi_device.sv ***
/*
 * Display controller receiver end: two-wire slave, control/payload split,
 * instruction decoder, display text RAM and power-up initialisation.
 * Assumes a master that keeps the link rules; SCL and SDA are sampled
 * by REF_CLK_IN, so SCL must stay well below a quarter of its rate.
 */
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
// Overview of operation
// [R1] Each byte followed by one acknowledge slot.
// [R2] Master clocks ninth pulse; transmitter releases SDA.
// [R3] Acknowledge address, control and data bytes.
// [R4] Acknowledger holds SDA low through ack pulse.
// [R5] Master nack ends reads; transmitter leaves SDA.
// [R6] Answer addresses 0111100 to 0111111 via straps.
// [R7] START, address; non-matching slaves ignore transfer.
// [R8] Command word: control byte then payload byte.
// [R9] Cleared continuation flag: only payload until STOP.
// [R10] Selector one: store in RAM, advance pointer.
// [R11] Selector zero: decode payload as instructions.
// [R12] Master ends every transmission with STOP; the master sends STOP only when the command's stop bit is set.
// [R13] No master acknowledge: stop sending bytes.
// [R14] Power-up initialisation holds busy flag high.
// [R15] Initialisation fills display RAM with 20H.
// [R16] Init: 8-bit width, one line, 5x8 font.
// [R17] Init: display, cursor and blink off.
// [R18] Init: increment by one, no display shift.
// [R19] Host initialises itself if internal reset fails.
// [R20] Refuse read requests by withholding address ack.
// [R21] START/STOP are SDA edges while SCL high.
// [R22] Two-wire use needs width select one, strap low.
`timescale 1ns/100ps
module lcdi_device (
	// Clock and reset.
	input  wire logic        REF_CLK_IN,
	input  wire logic        RESETN_IN,
	// Link.
	lcdi_if.device           link,
	// Address and mode straps.
	input  wire logic        ADDR_STRAP_BIT0_IN,
	input  wire logic        ADDR_STRAP_BIT1_IN,
	input  wire logic        CHIP_SELECT_STRAP_IN,
	// Display RAM read port.
	input  wire logic [6:0]  RD_ADDR_IN,
	output logic      [7:0]  RD_DATA_OUT,
	// Settings and status.
	output logic             BUSY_FLAG_OUT,
	output logic      [6:0]  DATA_POINTER_OUT,
	output logic             BUS_WIDTH_SELECT_OUT,
	output logic             LINE_COUNT_OUT,
	output logic             FONT_SELECT_OUT,
	output logic             DISPLAY_ON_OUT,
	output logic             CURSOR_ON_OUT,
	output logic             BLINK_ON_OUT,
	output logic             INCREMENT_OUT,
	output logic             SHIFT_ENABLE_OUT
);
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_RECV   = 4'b0010,
		ST_ACK    = 4'b0100,
		ST_IGNORE = 4'b1000
	} lcdi_dev_st_e;

	typedef enum logic [2:0] {
		PH_ADDR    = 3'b001,
		PH_CTRL    = 3'b010,
		PH_PAYLOAD = 3'b100
	} lcdi_phase_e;

	typedef struct packed {
		logic [3:0]            sync1;
		logic [3:0]            sync2;
		logic [1:0]            prev;
		lcdi_dev_st_e          st;
		lcdi_phase_e           ph;
		logic [3:0]            bitc;
		logic [7:0]            sh;
		logic                  sda_low;
		logic                  cont;
		logic                  sel;
		logic                  clr_act;
		logic [6:0]            clr_idx;
		logic [6:0]            ptr;
		logic                  inc;
		logic                  shift_en;
		logic                  disp;
		logic                  cur;
		logic                  blink;
		logic                  dl;
		logic                  lines;
		logic                  font;
		logic [7:0]            rd_data;
		logic [79:0][7:0]      ram;
	} lcdi_dev_s;

	// [R16] [R17] [R18] Power-up settings.
	localparam lcdi_dev_s RST_STATE = '{
		sync1: 4'hf, sync2: 4'hf, prev: 2'h3,
		st: ST_IDLE, ph: PH_ADDR, bitc: 4'h0, sh: 8'h00,
		sda_low: 1'b0, cont: 1'b0, sel: 1'b0,
		clr_act: 1'b1, clr_idx: 7'h00, ptr: 7'h00,
		inc: lcdi_pkg::INC_RST, shift_en: lcdi_pkg::SHIFT_RST,
		disp: lcdi_pkg::DISP_ON_RST, cur: lcdi_pkg::CURSOR_RST,
		blink: lcdi_pkg::BLINK_RST, dl: lcdi_pkg::BUS_WIDTH_RST,
		lines: lcdi_pkg::LINES_RST, font: lcdi_pkg::FONT_RST,
		rd_data: 8'h00, ram: '0
	};

	lcdi_dev_s r;
	lcdi_dev_s n;

	logic scl;
	logic sda;
	logic start_seen;
	logic stop_seen;
	logic scl_rise;
	logic scl_fall;
	logic addr_match;

	// Second synchroniser stage feeds all link logic.
	assign scl = r.sync2[3];
	assign sda = r.sync2[2];
	// [R21] Start and stop detection.
	assign start_seen = scl && r.prev[1] && r.prev[0] && !sda;
	assign stop_seen  = scl && r.prev[1] && !r.prev[0] && sda;
	assign scl_rise   = scl && !r.prev[1];
	assign scl_fall   = !scl && r.prev[1];
	// [R6] Strapped slave address.
	assign addr_match = (r.sh[7:1] == {lcdi_pkg::SLAVE_ADDR_HI, r.sync2[1], r.sync2[0]});

	function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic up);
		if (up) begin
			step_ptr = (p == lcdi_pkg::RAM_LAST) ? 7'h00 : p + 7'h01;
		end else begin
			step_ptr = (p == 7'h00) ? lcdi_pkg::RAM_LAST : p - 7'h01;
		end
	endfunction

	always_comb begin
		n = r;
		n.sync1 = {link.scl, link.sda, ADDR_STRAP_BIT1_IN, ADDR_STRAP_BIT0_IN};
		n.sync2 = r.sync1;
		n.prev = {scl, sda};
		n.rd_data = (RD_ADDR_IN <= lcdi_pkg::RAM_LAST) ? r.ram[RD_ADDR_IN] : 8'h00;

		// [R14] Busy while the RAM fill runs.
		if (r.clr_act) begin
			// [R15] Fill with blank code.
			n.ram[r.clr_idx] = lcdi_pkg::BLANK_CHAR;
			n.clr_idx = r.clr_idx + 7'h01;
			if (r.clr_idx == lcdi_pkg::RAM_LAST) begin
				n.clr_act = 1'b0;
				n.clr_idx = 7'h00;
				n.ptr = 7'h00;
			end
		end

		unique case (r.st)
			ST_IDLE, ST_IGNORE: begin
			end
			ST_RECV: begin
				if (scl_rise) begin
					n.sh = {r.sh[6:0], sda};
					n.bitc = r.bitc + 4'h1;
				end else if (scl_fall && r.bitc == 4'h8) begin
					// [R1] Eighth bit done, open the ack slot.
					n.bitc = 4'h0;
					n.st = ST_ACK;
					n.sda_low = 1'b1;
					unique case (r.ph)
						PH_ADDR: begin
							// [R7] Foreign address ignored.
							// [R20] Reads refused; hence nothing is ever transmitted.
							// [R13] No byte goes out, so a missing master ack has nothing to stop.
							if (!addr_match || r.sh[0]) begin
								n.st = ST_IGNORE;
								n.sda_low = 1'b0;
							end else begin
								n.ph = PH_CTRL;
							end
						end
						PH_CTRL: begin
							// [R8] Control byte carries flag and selector.
							n.cont = r.sh[lcdi_pkg::CTRL_CONT_BIT];
							n.sel = r.sh[lcdi_pkg::CTRL_SEL_BIT];
							n.ph = PH_PAYLOAD;
						end
						PH_PAYLOAD: begin
							// [R9] Cleared flag keeps payload phase.
							n.ph = r.cont ? PH_CTRL : PH_PAYLOAD;
							if (!r.clr_act && r.sel) begin
								// [R10] RAM write and pointer step.
								n.ram[r.ptr] = r.sh;
								n.ptr = step_ptr(r.ptr, r.inc);
							end else if (!r.clr_act) begin
								// [R11] Instruction decode.
								casez (r.sh)
									lcdi_pkg::INS_DISPLAY_TEXT_RAM: begin
										n.ptr = (r.sh[6:0] <= lcdi_pkg::RAM_LAST) ? r.sh[6:0] : 7'h00;
									end
									lcdi_pkg::INS_CGRAM: begin
									end
									lcdi_pkg::INS_FUNC: begin
										n.dl = r.sh[4];
										n.lines = r.sh[3];
										n.font = r.sh[2];
									end
									lcdi_pkg::INS_SHIFT: begin
										if (!r.sh[3]) begin
											n.ptr = step_ptr(r.ptr, r.sh[2]);
										end
									end
									lcdi_pkg::INS_ONOFF: begin
										n.disp = r.sh[2];
										n.cur = r.sh[1];
										n.blink = r.sh[0];
									end
									lcdi_pkg::INS_ENTRY: begin
										n.inc = r.sh[1];
										n.shift_en = r.sh[0];
									end
									lcdi_pkg::INS_HOME: begin
										n.ptr = 7'h00;
									end
									lcdi_pkg::INS_CLEAR: begin
										n.clr_act = 1'b1;
										n.clr_idx = 7'h00;
										n.inc = 1'b1;
									end
									default: begin
									end
								endcase
							end
						end
						default: begin
						end
					endcase
				end
			end
			ST_ACK: begin
				// [R3] [R4] Hold SDA low until the ninth clock falls.
				if (scl_fall) begin
					n.sda_low = 1'b0;
					n.st = ST_RECV;
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase

		if (start_seen) begin
			n.st = ST_RECV;
			n.ph = PH_ADDR;
			n.bitc = 4'h0;
			n.sda_low = 1'b0;
		end else if (stop_seen) begin
			n.st = ST_IDLE;
			n.sda_low = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			r <= RST_STATE;
		end else begin
			r <= n;
		end
	end

	assign link.sda_d_o = 1'b0;
	assign link.sda_d_oe = r.sda_low;
	assign RD_DATA_OUT = r.rd_data;
	assign BUSY_FLAG_OUT = r.clr_act;
	assign DATA_POINTER_OUT = r.ptr;
	assign BUS_WIDTH_SELECT_OUT = r.dl;
	assign LINE_COUNT_OUT = r.lines;
	assign FONT_SELECT_OUT = r.font;
	assign DISPLAY_ON_OUT = r.disp;
	assign CURSOR_ON_OUT = r.cur;
	assign BLINK_ON_OUT = r.blink;
	assign INCREMENT_OUT = r.inc;
	assign SHIFT_ENABLE_OUT = r.shift_en;
endmodule

// *** lcdi_host.sv ***
/*
 * Two-wire bus master end. Software writes one byte command at a time over
 * AXI4-Lite and polls status. SCL is made from REF_CLK_IN by a divider.
 * Assumes no clock stretching by the slave and a single master on the bus.
 */
`timescale 1ns/100ps
module lcdi_host (
	// Clock and reset.
	input  wire logic        REF_CLK_IN,
	input  wire logic        RESETN_IN,
	// Link.
	lcdi_if.host             link,
	// AXI4-Lite write channels.
	input  wire logic [3:0]  AXI_AWADDR_IN,
	input  wire logic        AXI_AWVALID_IN,
	output logic             AXI_AWREADY_OUT,
	input  wire logic [31:0] AXI_WDATA_IN,
	input  wire logic [3:0]  AXI_WSTRB_IN,
	input  wire logic        AXI_WVALID_IN,
	output logic             AXI_WREADY_OUT,
	output logic      [1:0]  AXI_BRESP_OUT,
	output logic             AXI_BVALID_OUT,
	input  wire logic        AXI_BREADY_IN,
	// AXI4-Lite read channels.
	input  wire logic [3:0]  AXI_ARADDR_IN,
	input  wire logic        AXI_ARVALID_IN,
	output logic             AXI_ARREADY_OUT,
	output logic      [31:0] AXI_RDATA_OUT,
	output logic      [1:0]  AXI_RRESP_OUT,
	output logic             AXI_RVALID_OUT,
	input  wire logic        AXI_RREADY_IN
);
	typedef enum logic [3:0] {
		HS_IDLE  = 4'b0001,
		HS_START = 4'b0010,
		HS_BITS  = 4'b0100,
		HS_STOP  = 4'b1000
	} lcdi_host_st_e;

	typedef struct packed {
		logic          sda1;
		logic          sda2;
		lcdi_host_st_e st;
		logic [7:0]    qcnt;
		logic [1:0]    qph;
		logic [3:0]    bitn;
		logic [8:0]    tx;
		logic [7:0]    rx;
		logic          do_stop;
		logic          nack;
		logic          scl_low;
		logic          sda_low;
		logic          aw_held;
		logic [3:0]    aw_addr;
		logic          w_held;
		logic [31:0]   w_data;
		logic          w_full;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          rvalid;
		logic [31:0]   rdata;
		logic [1:0]    rresp;
	} lcdi_host_s;

	lcdi_host_s r;
	lcdi_host_s n;
	logic       tick;
	logic       busy;

	assign tick = (r.qcnt == lcdi_pkg::SCL_QTR_LAST);
	assign busy = (r.st != HS_IDLE);

	always_comb begin
		n = r;
		n.sda1 = link.sda;
		n.sda2 = r.sda1;
		n.qcnt = (busy && !tick) ? r.qcnt + 8'h01 : 8'h00;

		// Register bus.
		if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
			n.aw_held = 1'b1;
			n.aw_addr = AXI_AWADDR_IN;
		end
		if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
			n.w_held = 1'b1;
			n.w_data = AXI_WDATA_IN;
			n.w_full = (AXI_WSTRB_IN == 4'hf);
		end
		if (r.bvalid && AXI_BREADY_IN) begin
			n.bvalid = 1'b0;
		end
		if (r.aw_held && r.w_held && !r.bvalid) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = lcdi_pkg::RESP_SLVERR;
			if (r.aw_addr == lcdi_pkg::REG_CMD && !busy && r.w_full) begin
				n.bresp = lcdi_pkg::RESP_OKAY;
				n.st = r.w_data[lcdi_pkg::CMD_START_BIT] ? HS_START : HS_BITS;
				n.qph = 2'h0;
				n.bitn = 4'h0;
				n.do_stop = r.w_data[lcdi_pkg::CMD_STOP_BIT];
				// [R5] Read releases data bits; nack ends reads.
				n.tx = r.w_data[lcdi_pkg::CMD_READ_BIT] ? {8'hff, r.w_data[lcdi_pkg::CMD_NACK_BIT]}
				                                         : {r.w_data[7:0], 1'b1};
			end
		end
		if (r.rvalid && AXI_RREADY_IN) begin
			n.rvalid = 1'b0;
		end
		if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
			n.rvalid = 1'b1;
			n.rresp = lcdi_pkg::RESP_OKAY;
			n.rdata = 32'h0000_0000;
			if (AXI_ARADDR_IN == lcdi_pkg::REG_STATUS) begin
				n.rdata[lcdi_pkg::STAT_BUSY_BIT] = busy;
				n.rdata[lcdi_pkg::STAT_NACK_BIT] = r.nack;
				n.rdata[lcdi_pkg::STAT_RX_LSB +: 8] = r.rx;
			end else if (AXI_ARADDR_IN != lcdi_pkg::REG_CMD) begin
				n.rresp = lcdi_pkg::RESP_SLVERR;
			end
		end

		// Link engine, one step per quarter of the SCL period.
		if (tick) begin
			n.qph = r.qph + 2'h1;
			unique case (r.st)
				HS_IDLE: begin
				end
				HS_START: begin
					// [R21] SDA falls while SCL is high.
					unique case (r.qph)
						2'h0: n.sda_low = 1'b0;
						2'h1: n.scl_low = 1'b0;
						2'h2: n.sda_low = 1'b1;
						default: begin
							n.scl_low = 1'b1;
							n.st = HS_BITS;
						end
					endcase
				end
				HS_BITS: begin
					unique case (r.qph)
						// [R2] Nine pulses; ninth bit is released for the ack, except on a read with the nack bit clear.
						2'h0: n.sda_low = !r.tx[8];
						2'h1: n.scl_low = 1'b0;
						2'h2: begin
							if (r.bitn == 4'h8) begin
								n.nack = r.sda2;
							end else begin
								n.rx = {r.rx[6:0], r.sda2};
							end
						end
						default: begin
							n.scl_low = 1'b1;
							n.tx = {r.tx[7:0], 1'b1};
							n.bitn = r.bitn + 4'h1;
							if (r.bitn == 4'h8) begin
								// [R12] Close with STOP when asked.
								n.st = r.do_stop ? HS_STOP : HS_IDLE;
							end
						end
					endcase
				end
				HS_STOP: begin
					unique case (r.qph)
						2'h0: n.sda_low = 1'b1;
						2'h1: n.scl_low = 1'b0;
						2'h2: n.sda_low = 1'b0;
						default: n.st = HS_IDLE;
					endcase
				end
				default: n.st = HS_IDLE;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			r <= '{sda1: 1'b1, sda2: 1'b1, st: HS_IDLE, tx: 9'h1ff, default: '0};
		end else begin
			r <= n;
		end
	end

	assign link.scl_m_o = 1'b0;
	assign link.scl_m_oe = r.scl_low;
	assign link.sda_m_o = 1'b0;
	assign link.sda_m_oe = r.sda_low;
	assign AXI_AWREADY_OUT = !r.aw_held && !r.bvalid;
	assign AXI_WREADY_OUT = !r.w_held && !r.bvalid;
	assign AXI_BRESP_OUT = r.bresp;
	assign AXI_BVALID_OUT = r.bvalid;
	assign AXI_ARREADY_OUT = !r.rvalid;
	assign AXI_RDATA_OUT = r.rdata;
	assign AXI_RRESP_OUT = r.rresp;
	assign AXI_RVALID_OUT = r.rvalid;
endmodule

// *** lcdi_link_monitor.sv ***
/*
 * Concurrent checks on the two-wire link between the bus master end and the
 * display receiver end. Assumes it sees every party's drive and the resolved
 * lines of the interface, sampled by the shared 100 MHz clock.
 */
`timescale 1ns/100ps
module lcdi_link_monitor (
	// Clock and reset.
	input  wire logic REF_CLK_IN,
	input  wire logic RESETN_IN,
	// Link drives and wire levels.
	input  wire logic scl_m_o,
	input  wire logic scl_m_oe,
	input  wire logic sda_m_o,
	input  wire logic sda_m_oe,
	input  wire logic sda_d_o,
	input  wire logic sda_d_oe,
	input  wire logic scl,
	input  wire logic sda
);
	logic       scl_q;
	logic       sda_q;
	logic [3:0] bit_cnt;
	logic [3:0] ack_rises;

	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!RESETN_IN);

	// Bit position since START, wrapping to zero on the rise of the acknowledge clock pulse.
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
			bit_cnt   <= 4'h0;
			ack_rises <= 4'h0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (scl && scl_q && sda_q && !sda)
				bit_cnt <= 4'h0;
			else if (scl && !scl_q)
				bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
			if (!sda_d_oe)
				ack_rises <= 4'h0;
			else if (scl && !scl_q)
				ack_rises <= ack_rises + 4'h1;
		end
	end

	sequence s_start;
		scl && scl_q && sda_q && !sda;
	endsequence
	sequence s_stop;
		scl && scl_q && !sda_q && sda;
	endsequence

	chk_od_low: assert property (!scl_m_o && !sda_m_o && !sda_d_o)
		else $error("a link output drives high");
	chk_ack_low: assert property (sda_d_oe && scl |-> !sda)
		else $error("data line not low during acknowledge");
	chk_ack_one_slot: assert property ($fell(sda_d_oe) |-> ack_rises == 4'h1)
		else $error("acknowledge did not span exactly one clock pulse");
	chk_ack_position: assert property ($rose(sda_d_oe) |-> bit_cnt == 4'h8)
		else $error("acknowledge not after the eighth bit");
	chk_oe_scl_low: assert property ($changed(sda_d_oe) |-> !scl && !scl_q)
		else $error("receiver changed data line while clock high");
	chk_no_contend: assert property (sda_d_oe && scl |-> !sda_m_oe)
		else $error("master did not release data line in acknowledge");
	chk_start_form: assert property (s_start |-> scl [*8] ##[1:300] !scl)
		else $error("clock not held then pulled after start");
	chk_stop_form: assert property (s_stop |-> (scl && sda) [*8])
		else $error("lines not left idle after stop");

	cover property ($rose(sda_d_oe));
	cover property (s_stop);
endmodule

// *** tb_top.sv ***
/*
 * Testbench joining the bus master end and the display receiver end.
 * Assumes the master end is driven over AXI4-Lite and the RAM read port.
 */
`timescale 1ns/100ps
module tb_top;
	logic        ref_clk;
	logic        resetn;
	logic        strap0;
	logic        strap1;
	logic [6:0]  rd_addr;
	logic [7:0]  rd_data;
	logic        busy;
	logic [6:0]  dptr;
	logic [7:0]  sets;
	logic [3:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [3:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic [7:0]  rnd;
	logic [7:0]  mset;
	int          mram [80];
	int          mptr;
	int          mphase;
	int          msel;
	int          bad_count;
	int          n_checks;

	lcdi_if link_if();
	lcdi_device lcdi_device_inst (.REF_CLK_IN(ref_clk), .RESETN_IN(resetn), .link(link_if),
		.ADDR_STRAP_BIT0_IN(strap0), .ADDR_STRAP_BIT1_IN(strap1), .CHIP_SELECT_STRAP_IN(1'b0),
		.RD_ADDR_IN(rd_addr), .RD_DATA_OUT(rd_data), .BUSY_FLAG_OUT(busy), .DATA_POINTER_OUT(dptr),
		.BUS_WIDTH_SELECT_OUT(sets[7]), .LINE_COUNT_OUT(sets[6]), .FONT_SELECT_OUT(sets[5]),
		.DISPLAY_ON_OUT(sets[4]), .CURSOR_ON_OUT(sets[3]), .BLINK_ON_OUT(sets[2]),
		.INCREMENT_OUT(sets[1]), .SHIFT_ENABLE_OUT(sets[0]));
	lcdi_host lcdi_host_inst (.REF_CLK_IN(ref_clk), .RESETN_IN(resetn), .link(link_if),
		.AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
		.AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
		.AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
		.AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
		.AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready));
	lcdi_link_monitor lcdi_link_monitor_inst (.REF_CLK_IN(ref_clk), .RESETN_IN(resetn),
		.scl_m_o(link_if.scl_m_o), .scl_m_oe(link_if.scl_m_oe), .sda_m_o(link_if.sda_m_o),
		.sda_m_oe(link_if.sda_m_oe), .sda_d_o(link_if.sda_d_o), .sda_d_oe(link_if.sda_d_oe),
		.scl(link_if.scl), .sda(link_if.sda));

	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
		@(posedge ref_clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge ref_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] b, input logic st, input logic sp, output logic nack);
		logic [31:0] cmd;
		logic [31:0] s;
		logic [1:0]  r;
		cmd = {24'h0, b};
		cmd[lcdi_pkg::CMD_START_BIT] = st;
		cmd[lcdi_pkg::CMD_STOP_BIT] = sp;
		axi_write(lcdi_pkg::REG_CMD, cmd, r);
		check("command response", 32'(lcdi_pkg::RESP_OKAY), 32'(r));
		s = 32'h1;
		while (s[lcdi_pkg::STAT_BUSY_BIT] !== 1'b0)
			axi_read(lcdi_pkg::REG_STATUS, s, r);
		nack = s[lcdi_pkg::STAT_NACK_BIT];
	endtask

	// Phase 0 waits for a control byte, 1 for its paired payload, 2 for payload until STOP.
	task automatic model_byte(input logic [7:0] b);
		if (mphase != 0) begin
			if (msel == 1) begin
				mram[mptr] = b;
				mptr = (mptr + 1) % lcdi_pkg::RAM_DEPTH;
			end else if (b[7:5] == 3'h1)
				mset[7:5] = b[4:2];
			else if (b[7:3] == 5'h01)
				mset[4:2] = b[2:0];
			else if (b[7:2] == 6'h01)
				mset[1:0] = b[1:0];
			else if (b == 8'h01) begin
				// Clear blanks the RAM, homes the pointer and restores increment.
				foreach (mram[i])
					mram[i] = 32'(lcdi_pkg::BLANK_CHAR);
				mptr = 0;
				mset[1] = 1'b1;
			end
			if (mphase == 1)
				mphase = 0;
		end else begin
			msel = b[lcdi_pkg::CTRL_SEL_BIT];
			mphase = b[lcdi_pkg::CTRL_CONT_BIT] ? 1 : 2;
		end
	endtask

	task automatic compare_all();
		check("settings", 32'(mset), 32'(sets));
		check("pointer", 32'(mptr), 32'(dptr));
		for (int i = 0; i <= lcdi_pkg::RAM_DEPTH; i++) begin
			@(posedge ref_clk);
			rd_addr <= 7'(i);
			@(posedge ref_clk);
			@(posedge ref_clk);
			check("ram", (i < lcdi_pkg::RAM_DEPTH) ? 32'(mram[i]) : 32'h0, 32'(rd_data));
		end
	endtask

	initial begin
		#1000000;
		bad_count++;
		$display("ERROR watchdog expected done seen timeout");
		stop_test();
	end

	initial begin
		logic        nack;
		logic [31:0] d;
		logic [1:0]  r;
		logic [6:0]  good;
		logic [7:0]  seq [5];
		logic [6:0][7:0] init_seq;
		int          cnt;
		bad_count = 0;
		n_checks = 0;
		rnd = 8'h61;
		resetn = 1'b0;
		{strap1, strap0} = rnd[1:0];
		{rd_addr, awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
		wstrb = 4'hf;
		foreach (mram[i])
			mram[i] = 32'(lcdi_pkg::BLANK_CHAR);
		{mptr, mphase, msel} = '0;
		mset = {lcdi_pkg::BUS_WIDTH_RST, lcdi_pkg::LINES_RST, lcdi_pkg::FONT_RST, lcdi_pkg::DISP_ON_RST,
			lcdi_pkg::CURSOR_RST, lcdi_pkg::BLINK_RST, lcdi_pkg::INC_RST, lcdi_pkg::SHIFT_RST};
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		cnt = 0;
		// Busy is read between edges, where it has settled.
		@(negedge ref_clk);
		check("busy after reset", 32'h1, 32'(busy));
		while (busy !== 1'b0 && cnt < 200) begin
			@(negedge ref_clk);
			cnt++;
		end
		check("busy span in range", 32'h1, 32'(cnt >= 78 && cnt <= 82));
		check("busy", 32'h0, 32'(busy));
		compare_all();
		$display("test power-up initialisation done");
		good = {lcdi_pkg::SLAVE_ADDR_HI, strap1, strap0};
		send_byte({good ^ 7'h01, 1'b0}, 1'b1, 1'b0, nack);
		check("nack other address", 32'h1, 32'(nack));
		send_byte({good, 1'b1}, 1'b1, 1'b0, nack);
		check("nack read request", 32'h1, 32'(nack));
		$display("test address refusal done");
		rnd = lfsr_next(rnd);
		seq[3] = rnd | 8'h80;
		rnd = lfsr_next(rnd);
		seq[4] = rnd;
		seq[0] = 8'h80;
		seq[1] = 8'h0f;
		seq[2] = 8'h40;
		send_byte({good, 1'b0}, 1'b1, 1'b0, nack);
		check("ack own address", 32'h0, 32'(nack));
		for (int i = 0; i < 5; i++) begin
			send_byte(seq[i], 1'b0, 1'(i == 4), nack);
			check("ack byte", 32'h0, 32'(nack));
			model_byte(seq[i]);
		end
		check("lines idle after stop", 32'h3, 32'({link_if.scl, link_if.sda}));
		compare_all();
		$display("test command and data write done");
		// Host-driven initialisation, preceded by non-default settings to show each one but the bus width lands.
		init_seq = {8'h00, 8'h3c, 8'h05, 8'h30, 8'h08, 8'h06, 8'h01};
		mphase = 0;
		send_byte({good, 1'b0}, 1'b1, 1'b0, nack);
		check("ack own address", 32'h0, 32'(nack));
		for (int i = 6; i >= 0; i--) begin
			send_byte(init_seq[i], 1'b0, 1'(i == 0), nack);
			check("ack instruction", 32'h0, 32'(nack));
			model_byte(init_seq[i]);
			check("settings", 32'(mset), 32'(sets));
		end
		compare_all();
		$display("test host initialisation done");
		axi_write(4'h8, 32'h0, r);
		check("unmapped write response", 32'(lcdi_pkg::RESP_SLVERR), 32'(r));
		axi_read(4'hc, d, r);
		check("unmapped read response", 32'(lcdi_pkg::RESP_SLVERR), 32'(r));
		check("unmapped read data", 32'h0, d);
		$display("test register errors done");
		stop_test();
	end
endmodule
